// File: src/ide_function_config_header.sv
// Purpose: Configuration header registers of the integrated IDE function
// Assumes: Config reads and writes and all events run on ref_clk; reset is synchronous
// Notes: Read data answers one cycle after the read request
//
// Notes on behaviour
// - Master abort sets sticky flag; one clears
// - Target abort sets sticky flag; one clears
// - Select timing field reads fixed 01
// - Fast back-to-back bit reads one; 0280h
// - Error, user, 66 MHz bits read zero
// - Bus master bit one, bits 6:4 zero
// - Both channel capability bits read one
// - Bit 2 selects secondary mode, resets legacy
// - Bit 0 selects primary mode; byte 8Ah
// - Sub-class byte reads constant 01h
// - Base class byte reads constant 01
// - Latency timer hardwired zero, writes ignored
// - Command base: bits 15:3 writable only
// - Control base: bits 15:2 writable only
// - Base bit 0 reads one, I/O
// - Primary command window only in native mode
// - Native with I/O off masks interrupt

`timescale 1ns/1ps
`default_nettype none

module ide_function_config_header
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ide_cfg_pkg::cfg_req_s cfgReq,
    output var logic [31:0] cfgRdData,
    output var logic cfgRdValid,
    input wire logic masterAbortEvent,
    input wire logic targetAbortEvent,
    input wire logic ioSpaceEnable,
    input wire ide_cfg_pkg::io_req_s ioReq,
    output var logic [3:0] windowHit,
    output var logic primaryNative,
    output var logic secondaryNative,
    input wire logic ideIrqIn,
    output var logic ideIrqOut
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] dwordOf(input logic [7:0] ofs);
        dwordOf = ofs[7:2];
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = wr[i*8 +: 8];
        end
        mergeBytes = res;
    endfunction

    function automatic logic [31:0] baseMaskOf(input int idx);
        baseMaskOf = (idx % 2 == 0) ? ide_cfg_pkg::CMD_BASE_MASK : ide_cfg_pkg::CTL_BASE_MASK;
    endfunction

    function automatic logic [5:0] baseDwordOf(input int idx);
        logic [5:0] res;
        res = dwordOf(ide_cfg_pkg::OFS_PRI_CMD_BASE);
        case (idx)
            1: res = dwordOf(ide_cfg_pkg::OFS_PRI_CTL_BASE);
            2: res = dwordOf(ide_cfg_pkg::OFS_SEC_CMD_BASE);
            3: res = dwordOf(ide_cfg_pkg::OFS_SEC_CTL_BASE);
            default: res = dwordOf(ide_cfg_pkg::OFS_PRI_CMD_BASE);
        endcase
        baseDwordOf = res;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic statusSel;
    wire logic classSel;
    wire logic latencySel;
    wire logic [3:0] baseSel;
    wire logic statusHighWrite;
    wire logic progIfWrite;

    assign statusSel = (cfgReq.dwordIndex == dwordOf(ide_cfg_pkg::OFS_STATUS));
    assign classSel = (cfgReq.dwordIndex == dwordOf(ide_cfg_pkg::OFS_PROG_IF));
    assign latencySel = (cfgReq.dwordIndex == dwordOf(ide_cfg_pkg::OFS_LATENCY));
    assign statusHighWrite = cfgReq.write & statusSel & cfgReq.byteEn[ide_cfg_pkg::OFS_STATUS[1:0] + 2'd1];
    assign progIfWrite = cfgReq.write & classSel & cfgReq.byteEn[ide_cfg_pkg::OFS_PROG_IF[1:0]];

    genvar g;
    generate
        for (g = 0; g < ide_cfg_pkg::NUM_BASES; g++)
        begin : gen_sel
            assign baseSel[g] = (cfgReq.dwordIndex == baseDwordOf(g));
        end
    endgenerate

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    wire logic [31:0] wrStatusWord;
    wire logic masterAbortClear;
    wire logic targetAbortClear;
    logic masterAbortReceived;
    logic targetAbortSignaled;

    // Status sits in the upper half of its dword
    assign wrStatusWord = cfgReq.data >> 16;
    // Only a one in the flag position clears; zeros leave the flag alone
    assign masterAbortClear = statusHighWrite & wrStatusWord[ide_cfg_pkg::STS_MASTER_ABORT_BIT];
    assign targetAbortClear = statusHighWrite & wrStatusWord[ide_cfg_pkg::STS_TARGET_ABORT_BIT];

    w1c_status_flag u_master_abort
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .setEvent(masterAbortEvent),
        .clearStrobe(masterAbortClear),
        .flag(masterAbortReceived)
    );

    w1c_status_flag u_target_abort
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .setEvent(targetAbortEvent),
        .clearStrobe(targetAbortClear),
        .flag(targetAbortSignaled)
    );

    // Fixed bits supply select timing, fast back-to-back and zero error bits
    wire logic [15:0] functionStatus;
    assign functionStatus = ide_cfg_pkg::STATUS_FIXED
                            | (16'(masterAbortReceived) << ide_cfg_pkg::STS_MASTER_ABORT_BIT)
                            | (16'(targetAbortSignaled) << ide_cfg_pkg::STS_TARGET_ABORT_BIT);

    // ------------------------------------------------------------
    // Programming interface and base registers
    // ------------------------------------------------------------
    logic [7:0] programmingInterface;
    logic [31:0] baseReg [ide_cfg_pkg::NUM_BASES];
    wire logic [7:0] wrProgIf;
    wire logic [7:0] next_programmingInterface;

    assign wrProgIf = cfgReq.data[ide_cfg_pkg::OFS_PROG_IF[1:0]*8 +: 8];
    // Only the two mode selects take the write; the rest stay at 8Ah pattern
    assign next_programmingInterface = (programmingInterface & ~ide_cfg_pkg::PROG_IF_WRITABLE)
                                       | (wrProgIf & ide_cfg_pkg::PROG_IF_WRITABLE);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            programmingInterface <= ide_cfg_pkg::PROG_IF_RESET;
        else if (progIfWrite)
            programmingInterface <= next_programmingInterface;
    end

    generate
        for (g = 0; g < ide_cfg_pkg::NUM_BASES; g++)
        begin : gen_base
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                    baseReg[g] <= ide_cfg_pkg::BASE_IO_FLAG;
                else if (cfgReq.write && baseSel[g])
                    // Reserved bits are masked off, the I/O flag forced
                    baseReg[g] <= (mergeBytes(baseReg[g], cfgReq.data, cfgReq.byteEn) & baseMaskOf(g))
                                  | ide_cfg_pkg::BASE_IO_FLAG;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode outputs and I/O window decode
    // ------------------------------------------------------------
    wire logic priSel;
    wire logic secSel;
    assign priSel = programmingInterface[ide_cfg_pkg::PROG_IF_PRI_SEL_BIT];
    assign secSel = programmingInterface[ide_cfg_pkg::PROG_IF_SEC_SEL_BIT];

    // Mixed modes are not guarded here; software keeps both selects alike
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            primaryNative <= 1'b0;
            secondaryNative <= 1'b0;
        end
        else
        begin
            primaryNative <= priSel;
            secondaryNative <= secSel;
        end
    end

    generate
        for (g = 0; g < ide_cfg_pkg::NUM_BASES; g++)
        begin : gen_window
            wire logic winEnable;
            // Native windows only answer while that channel is native
            assign winEnable = ioSpaceEnable & ((g < 2) ? priSel : secSel);
            io_window_decode u_window
            (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .baseMask(baseMaskOf(g)),
                .baseValue(baseReg[g]),
                .windowEnable(winEnable),
                .ioReq(ioReq),
                .hit(windowHit[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt masking
    // ------------------------------------------------------------
    wire logic irqMasked;
    // Level passes through, so a pending interrupt reappears once unmasked
    assign irqMasked = (priSel | secSel) & ~ioSpaceEnable;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ideIrqOut <= 1'b0;
        else
            ideIrqOut <= ideIrqIn & ~irqMasked;
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [31:0] classWord;
    wire logic [31:0] latencyWord;
    logic [31:0] next_cfgRdData;

    // Revision byte is not held by this block and reads zero
    assign classWord = {ide_cfg_pkg::BASE_CLASS_VALUE, ide_cfg_pkg::SUB_CLASS_VALUE,
                        programmingInterface, 8'h00};
    assign latencyWord = 32'(ide_cfg_pkg::LATENCY_VALUE) << (ide_cfg_pkg::OFS_LATENCY[1:0] * 8);

    always_comb
    begin
        next_cfgRdData = 32'h00000000;
        if (statusSel)
            next_cfgRdData = {functionStatus, 16'h0000};
        else if (classSel)
            next_cfgRdData = classWord;
        else if (latencySel)
            next_cfgRdData = latencyWord;
        else
        begin
            for (int i = 0; i < ide_cfg_pkg::NUM_BASES; i++)
            begin
                if (baseSel[i])
                    next_cfgRdData = baseReg[i];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cfgRdData <= 32'h00000000;
            cfgRdValid <= 1'b0;
        end
        else
        begin
            cfgRdValid <= cfgReq.read;
            cfgRdData <= cfgReq.read ? next_cfgRdData : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_master_abort_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        masterAbortEvent |=> functionStatus[ide_cfg_pkg::STS_MASTER_ABORT_BIT])
        else $error("master abort flag not set");

    a_target_abort_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
        targetAbortClear && !targetAbortEvent |=> !functionStatus[ide_cfg_pkg::STS_TARGET_ABORT_BIT])
        else $error("target abort flag not cleared");

    a_status_fixed_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (functionStatus & ~16'h2800) == 16'h0280)
        else $error("status fixed bits wrong");

    a_status_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfgReq.read && statusSel && !masterAbortReceived && !targetAbortSignaled
        && !masterAbortEvent && !targetAbortEvent |=> cfgRdData == 32'h02800000)
        else $error("status read not 0280h");

    a_status_zero_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        functionStatus[15:14] == 2'b00 && functionStatus[8] == 1'b0 && functionStatus[6:5] == 2'b00)
        else $error("status error bits not zero");

    a_progif_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (programmingInterface & 8'hFA) == 8'h8A)
        else $error("programming interface fixed bits wrong");

    a_mode_select_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        progIfWrite |=> priSel == $past(wrProgIf[0]) && secSel == $past(wrProgIf[2]) ##1
        primaryNative == priSel)
        else $error("mode select not taken");

    a_class_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfgReq.read && classSel |=> cfgRdData[31:16] == 16'h0101 && cfgRdValid)
        else $error("class code read wrong");

    a_latency_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfgReq.read && latencySel |=> cfgRdData == 32'h00000000)
        else $error("latency timer not zero");

    a_cmd_base_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (baseReg[0] & 32'hFFFF0006) == 32'h00000000 && (baseReg[2] & 32'hFFFF0006) == 32'h00000000)
        else $error("command base reserved bits set");

    a_ctl_base_io: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (baseReg[1] & 32'hFFFF0003) == 32'h00000001 && baseReg[3][0])
        else $error("control base fixed bits wrong");

    a_legacy_no_hit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !priSel |=> !windowHit[0])
        else $error("primary command window hit in legacy mode");

    a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ideIrqIn && (priSel || secSel) && !ioSpaceEnable |=> !ideIrqOut)
        else $error("interrupt not masked");

    a_irq_unmasked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ideIrqIn && ioSpaceEnable |=> ideIrqOut)
        else $error("pending interrupt not passed");

    a_zero_write_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        statusHighWrite && !masterAbortClear && masterAbortReceived |=> masterAbortReceived)
        else $error("zero write cleared flag");

endmodule

`default_nettype wire

// File: src/ide_cfg_pkg.sv
// Purpose: Shared constants and carriers for the IDE function configuration header
// Assumes: Config accesses are dword-wide with byte enables, as on a PCI-style config cycle
// Notes: Offsets are byte offsets; dword index is the offset divided by four

package ide_cfg_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h06;
    localparam logic [7:0] OFS_PROG_IF = 8'h09;
    localparam logic [7:0] OFS_SUB_CLASS = 8'h0A;
    localparam logic [7:0] OFS_BASE_CLASS = 8'h0B;
    localparam logic [7:0] OFS_LATENCY = 8'h0D;
    localparam logic [7:0] OFS_PRI_CMD_BASE = 8'h10;
    localparam logic [7:0] OFS_PRI_CTL_BASE = 8'h14;
    localparam logic [7:0] OFS_SEC_CMD_BASE = 8'h18;
    localparam logic [7:0] OFS_SEC_CTL_BASE = 8'h1C;

    // ------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------
    localparam int STS_MASTER_ABORT_BIT = 13;
    localparam int STS_TARGET_ABORT_BIT = 11;
    localparam logic [15:0] STATUS_FIXED = 16'h0280;
    localparam logic [7:0] PROG_IF_RESET = 8'h8A;
    localparam logic [7:0] PROG_IF_WRITABLE = 8'h05;
    localparam int PROG_IF_PRI_SEL_BIT = 0;
    localparam int PROG_IF_SEC_SEL_BIT = 2;
    localparam logic [7:0] SUB_CLASS_VALUE = 8'h01;
    localparam logic [7:0] BASE_CLASS_VALUE = 8'h01;
    localparam logic [7:0] LATENCY_VALUE = 8'h00;
    localparam logic [31:0] CMD_BASE_MASK = 32'h0000FFF8;
    localparam logic [31:0] CTL_BASE_MASK = 32'h0000FFFC;
    localparam logic [31:0] BASE_IO_FLAG = 32'h00000001;
    localparam int NUM_BASES = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic read;
        logic [5:0] dwordIndex;
        logic [3:0] byteEn;
        logic [31:0] data;
    } cfg_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } io_req_s;

endpackage

// File: src/w1c_status_flag.sv
// Purpose: One sticky status flag, set by hardware and cleared by writing one
// Assumes: Set and clear strobes are on ref_clk
// Notes: A set in the clearing cycle wins so no event is lost

`timescale 1ns/1ps
`default_nettype none

module w1c_status_flag
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic setEvent,
    input wire logic clearStrobe,
    output var logic flag
);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            flag <= 1'b0;
        else if (setEvent)
            flag <= 1'b1;
        else if (clearStrobe)
            flag <= 1'b0;
    end

    a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) setEvent |=> flag)
        else $error("flag not set after event");

endmodule

`default_nettype wire

// File: src/io_window_decode.sv
// Purpose: Registered hit detect for one I/O window located by a base register
// Assumes: Address arrives on ref_clk; mask keeps the base bits that take part
// Notes: Hit is one cycle after the request

`timescale 1ns/1ps
`default_nettype none

module io_window_decode
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [31:0] baseMask,
    input wire logic [31:0] baseValue,
    input wire logic windowEnable,
    input wire ide_cfg_pkg::io_req_s ioReq,
    output var logic hit
);

    logic match;

    assign match = ((ioReq.addr & baseMask[15:0]) == (baseValue[15:0] & baseMask[15:0]));

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            hit <= 1'b0;
        else
            hit <= ioReq.valid & windowEnable & match;
    end

endmodule

`default_nettype wire

// File: test/ide_function_config_header_tb.sv
// Purpose: Self-checking bench for the IDE function config header
// Assumes: Inputs driven by NBA on ref_clk rising edges; outputs sampled 1 ns after an edge
// Notes: Expected values are built from the register rules, never read back from the block

`timescale 1ns/1ps
`default_nettype none

module ide_function_config_header_tb;

    localparam int TIMEOUT = 3000;

    logic ref_clk;
    logic rst_n;
    ide_cfg_pkg::cfg_req_s cfgReq;
    logic [31:0] cfgRdData;
    logic cfgRdValid;
    logic masterAbortEvent;
    logic targetAbortEvent;
    logic ioSpaceEnable;
    ide_cfg_pkg::io_req_s ioReq;
    logic [3:0] windowHit;
    logic primaryNative;
    logic secondaryNative;
    logic ideIrqIn;
    logic ideIrqOut;
    int errors;
    int checkCount;
    int cycles = 0;

    ide_function_config_header dut_u
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cfgReq(cfgReq),
        .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid),
        .masterAbortEvent(masterAbortEvent),
        .targetAbortEvent(targetAbortEvent),
        .ioSpaceEnable(ioSpaceEnable),
        .ioReq(ioReq),
        .windowHit(windowHit),
        .primaryNative(primaryNative),
        .secondaryNative(secondaryNative),
        .ideIrqIn(ideIrqIn),
        .ideIrqOut(ideIrqOut)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
        checkCount++;
        if (seen !== expected)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, expected);
        end
    endtask

    task automatic cfg_write(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] data);
        @(posedge ref_clk);
        cfgReq <= '{write: 1'b1, read: 1'b0, dwordIndex: idx, byteEn: be, data: data};
        @(posedge ref_clk);
        cfgReq <= '0;
    endtask

    // Read answer lands on the taking edge and is checked 1 ns later
    task automatic cfg_read(input logic [5:0] idx, input logic [31:0] expected, input string what);
        @(posedge ref_clk);
        cfgReq <= '{write: 1'b0, read: 1'b1, dwordIndex: idx, byteEn: 4'h0, data: 32'h0};
        @(posedge ref_clk);
        cfgReq <= '0;
        #1;
        check({31'h0, cfgRdValid}, 32'h1, "read valid");
        check(cfgRdData, expected, what);
        // Valid is a one-cycle pulse and data returns to zero behind it
        @(posedge ref_clk);
        #1;
        check({31'h0, cfgRdValid}, 32'h0, "valid one cycle");
        check(cfgRdData, 32'h00000000, "data idle zero");
    endtask

    task automatic io_probe(input logic [15:0] addr, input logic [3:0] expected);
        @(posedge ref_clk);
        ioReq <= '{valid: 1'b1, addr: addr};
        @(posedge ref_clk);
        ioReq <= '0;
        #1;
        check({28'h0, windowHit}, {28'h0, expected}, "window hit");
    endtask

    task automatic irq_step(input logic irqIn, input logic ioEn, input logic expected);
        @(posedge ref_clk);
        ideIrqIn <= irqIn;
        ioSpaceEnable <= ioEn;
        @(posedge ref_clk);
        #1;
        check({31'h0, ideIrqOut}, {31'h0, expected}, "irq out");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        cfg_read(6'h01, 32'h02800000, "status reset");
        cfg_read(6'h02, 32'h01018A00, "class and prog if");
        cfg_read(6'h03, 32'h00000000, "latency");
        for (int i = 4; i < 8; i++)
            cfg_read(i[5:0], 32'h00000001, "base reset");
        $display("test_reset_values done");
    endtask

    task automatic test_readonly_writes();
        cfg_write(6'h01, 4'hF, 32'hFFFFFFFF);
        cfg_write(6'h03, 4'hF, 32'hFFFFFFFF);
        cfg_write(6'h08, 4'hF, 32'hFFFFFFFF);
        cfg_read(6'h01, 32'h02800000, "status after ones");
        cfg_read(6'h03, 32'h00000000, "latency after ones");
        cfg_read(6'h08, 32'h00000000, "unmapped dword");
        // Both mode bits move together in these writes
        cfg_write(6'h02, 4'hF, 32'hFFFFFFFF);
        cfg_read(6'h02, 32'h01018F00, "prog if native");
        cfg_write(6'h02, 4'h2, 32'h00000000);
        cfg_read(6'h02, 32'h01018A00, "prog if legacy");
        $display("test_readonly_writes done");
    endtask

    task automatic test_status_flags();
        @(posedge ref_clk);
        masterAbortEvent <= 1'b1;
        @(posedge ref_clk);
        masterAbortEvent <= 1'b0;
        cfg_read(6'h01, 32'h22800000, "master abort set");
        @(posedge ref_clk);
        targetAbortEvent <= 1'b1;
        @(posedge ref_clk);
        targetAbortEvent <= 1'b0;
        cfg_read(6'h01, 32'h2A800000, "target abort set");
        cfg_write(6'h01, 4'hC, 32'h00000000);
        cfg_read(6'h01, 32'h2A800000, "zero write keeps flags");
        cfg_write(6'h01, 4'h8, 32'h20000000);
        cfg_read(6'h01, 32'h0A800000, "master flag cleared");
        cfg_write(6'h01, 4'h8, 32'h08000000);
        cfg_read(6'h01, 32'h02800000, "target flag cleared");
        // Event and clear in one cycle: the event must win
        @(posedge ref_clk);
        masterAbortEvent <= 1'b1;
        cfgReq <= '{write: 1'b1, read: 1'b0, dwordIndex: 6'h01, byteEn: 4'h8, data: 32'h20000000};
        @(posedge ref_clk);
        masterAbortEvent <= 1'b0;
        cfgReq <= '0;
        cfg_read(6'h01, 32'h22800000, "set beats clear");
        cfg_write(6'h01, 4'h8, 32'h20000000);
        cfg_read(6'h01, 32'h02800000, "flag cleared again");
        $display("test_status_flags done");
    endtask

    task automatic test_base_fields();
        for (int i = 4; i < 8; i++)
            cfg_write(i[5:0], 4'hF, 32'hFFFFFFFF);
        cfg_read(6'h04, 32'h0000FFF9, "pri cmd base");
        cfg_read(6'h05, 32'h0000FFFD, "pri ctl base");
        cfg_read(6'h06, 32'h0000FFF9, "sec cmd base");
        cfg_read(6'h07, 32'h0000FFFD, "sec ctl base");
        $display("test_base_fields done");
    endtask

    task automatic test_window_decode();
        cfg_write(6'h04, 4'hF, 32'h000001F0);
        cfg_write(6'h05, 4'h1, 32'h000003F4);
        cfg_write(6'h05, 4'h2, 32'h000003F4);
        cfg_write(6'h06, 4'hF, 32'h00000170);
        cfg_write(6'h07, 4'hF, 32'h00000374);
        ioSpaceEnable <= 1'b1;
        io_probe(16'h01F0, 4'h0);
        cfg_write(6'h02, 4'h2, 32'h00000500);
        @(posedge ref_clk);
        #1;
        check({30'h0, primaryNative, secondaryNative}, 32'h3, "native outputs");
        io_probe(16'h01F0, 4'h1);
        io_probe(16'h01F7, 4'h1);
        io_probe(16'h01F8, 4'h0);
        io_probe(16'h03F3, 4'h0);
        io_probe(16'h03F4, 4'h2);
        io_probe(16'h03F7, 4'h2);
        io_probe(16'h0177, 4'h4);
        io_probe(16'h0374, 4'h8);
        io_probe(16'h0378, 4'h0);
        @(posedge ref_clk);
        ioSpaceEnable <= 1'b0;
        io_probe(16'h01F0, 4'h0);
        $display("test_window_decode done");
    endtask

    task automatic test_irq_mask();
        irq_step(1'b1, 1'b0, 1'b0);
        irq_step(1'b1, 1'b1, 1'b1);
        irq_step(1'b0, 1'b1, 1'b0);
        cfg_write(6'h02, 4'h2, 32'h00000000);
        @(posedge ref_clk);
        irq_step(1'b1, 1'b0, 1'b1);
        $display("test_irq_mask done");
    endtask

    task automatic test_mid_reset();
        cfg_write(6'h02, 4'h2, 32'h00000500);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check({30'h0, primaryNative, secondaryNative}, 32'h0, "natives after reset");
        cfg_read(6'h02, 32'h01018A00, "prog if after reset");
        cfg_read(6'h04, 32'h00000001, "base after reset");
        $display("test_mid_reset done");
    endtask

    // ------------------------------------------------------------
    // Timeout and main sequence
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
    end

    initial
    begin
        errors = 0;
        checkCount = 0;
        rst_n = 1'b0;
        cfgReq = '0;
        masterAbortEvent = 1'b0;
        targetAbortEvent = 1'b0;
        ioSpaceEnable = 1'b0;
        ioReq = '0;
        ideIrqIn = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Watchdog branch so a hang still reaches the one verdict
        fork
            begin
                test_reset_values();
                test_readonly_writes();
                test_status_flags();
                test_base_fields();
                test_window_decode();
                test_irq_mask();
                test_mid_reset();
            end
            begin
                wait (cycles == TIMEOUT);
                errors++;
                $display("unexpected at %0t: run exceeded cycle limit", $time);
            end
        join_any
        end_sim();
    end

endmodule

`default_nettype wire
